// >>> rtl/adc_regs.sv
// result, identification and output control registers of the converter
// assumes a 4-wire serial host, mode 3, clock well below core clock / 8
//
// Operation
// - pseudo mode: upper code picks positive, common negative
// - read-only 24-bit result at code 011
// - result read done sets ready bit and pin
// - append mode sends status after result
// - status low nibble holds conversion channel code
// - read-only identification register at code 100
// - 8-bit output control at code 101, reset zero
// - output control shifted most significant bit first
// - upper enable drives pins 3 and 2
// - upper enable clear: pins 3, 2 analog
// - lower enable drives pins 1 and 0
// - lower enable clear: pins 1, 0 undriven
// - reference select, lower enable clear: pins 1, 0 reference
// - both clear: pins 1, 0 analog inputs
// - pin 3 follows level bit 3
// - pin 2 follows level bit 2
// - pins 1, 0 follow level bits
// - read returns pin state when pair enabled
// - all registers reached over 4-wire serial port
`include "adc_regs_defs.svh"
`timescale 1ns/1ps
module adc_regs
    import adc_regs_pkg::*;
#(
    parameter logic [7:0] ID_VALUE = 8'hA5 // arbitrary identification value
) (
    input wire logic CORE_CLK_I,
    input wire logic RESETN_I,
    input wire logic SPI_SCLK_I,
    input wire logic SPI_CS_N_I,
    input wire logic SPI_DIN_I,
    output logic SPI_DOUT_O,
    output logic SPI_DOUT_OE_O,
    output logic READY_O,
    input wire logic [7:0] CHAN_SEL_I,
    input wire logic PSEUDO_I,
    input wire logic APPEND_STATUS_ENABLE_I,
    input wire logic REFERENCE_SELECT_I,
    input wire logic CONV_DONE_I,
    input wire logic [23:0] CONV_RESULT_I,
    output logic [3:0] POS_INPUT_CODE_O,
    output logic [3:0] NEG_INPUT_CODE_O,
    output logic NEG_IS_COMMON_O,
    input wire logic [3:0] GP_PIN_I,
    output logic [3:0] GP_PIN_O,
    output logic [3:0] GP_PIN_OE_O,
    output logic UPPER_ANALOG_O,
    output logic LOWER_REF2_O,
    output logic LOWER_ANALOG_O
);

    // ==========================================
    // pin synchronisation
    spi_pins_s spi;
    logic [3:0] gp_pin_sync;
    logic [6:0] sync_w;

    // serial clock and select reset to idle high, so no false edge or select
    sync_two_stage #(
        .WIDTH(7),
        .RESET_VAL(7'h60)
    ) u_sync (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RESETN_I),
        .async_i({SPI_SCLK_I, SPI_CS_N_I, SPI_DIN_I, GP_PIN_I}),
        .sync_o(sync_w)
    );

    assign spi = spi_pins_s'(sync_w[6:4]);
    assign gp_pin_sync = sync_w[3:0];

    // ==========================================
    // serial clock edges
    logic sclk_prev_q;
    logic sclk_prev_d;
    logic sclk_rise;
    logic sclk_fall;

    always_comb begin
        sclk_prev_d = spi.sclk;
    end

    // idle level of mode 3 is high
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            sclk_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_prev_d;
        end
    end

    assign sclk_rise = spi.sclk & ~sclk_prev_q;
    assign sclk_fall = ~spi.sclk & sclk_prev_q;

    // ==========================================
    // channel decode and routing
    logic [3:0] pos_code_q;
    logic [3:0] pos_code_d;
    logic [3:0] neg_code_q;
    logic [3:0] neg_code_d;
    logic neg_common_q;
    logic neg_common_d;
    route_s route_q;
    route_s route_d;
    logic [7:0] gpo_q;
    logic [7:0] gpo_d;
    logic upper_en;
    logic lower_en;

    assign upper_en = gpo_q[`GPO_UPPER_EN_BIT];
    assign lower_en = gpo_q[`GPO_LOWER_EN_BIT];

    always_comb begin
        pos_code_d = CHAN_SEL_I[7:4];
        neg_code_d = PSEUDO_I ? 4'h0 : CHAN_SEL_I[3:0];
        neg_common_d = PSEUDO_I;
        route_d.upper_analog = ~upper_en;
        route_d.lower_ref2 = ~lower_en & REFERENCE_SELECT_I;
        route_d.lower_analog = ~lower_en & ~REFERENCE_SELECT_I;
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            pos_code_q <= 4'h0;
            neg_code_q <= 4'h0;
            neg_common_q <= 1'b0;
            route_q <= 3'b101;
        end else begin
            pos_code_q <= pos_code_d;
            neg_code_q <= neg_code_d;
            neg_common_q <= neg_common_d;
            route_q <= route_d;
        end
    end

    // ==========================================
    // serial transfer engine
    spi_phase_e phase_q;
    spi_phase_e phase_d;
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic [5:0] len_q;
    logic [5:0] len_d;
    logic [2:0] rs_q;
    logic [2:0] rs_d;
    logic [7:0] cmd_sh_q;
    logic [7:0] cmd_sh_d;
    logic [31:0] rd_sh_q;
    logic [31:0] rd_sh_d;
    logic [7:0] wr_sh_q;
    logic [7:0] wr_sh_d;
    logic dout_q;
    logic dout_d;
    logic result_read_done;
    logic gpo_write;
    logic [7:0] gpo_wdata;
    logic [7:0] cmd_full;
    logic [7:0] status_word;
    logic [7:0] gpo_read;
    conv_s conv_q;
    conv_s conv_d;
    logic rdy_q;
    logic rdy_d;

    // status and output control read views
    assign status_word = {rdy_q, 3'b000, conv_q.chan};
    assign gpo_read = {gpo_q[7:4],
        upper_en ? gp_pin_sync[3:2] : gpo_q[3:2],
        lower_en ? gp_pin_sync[1:0] : gpo_q[1:0]};

    always_comb begin
        phase_d = phase_q;
        cnt_d = cnt_q;
        len_d = len_q;
        rs_d = rs_q;
        cmd_sh_d = cmd_sh_q;
        rd_sh_d = rd_sh_q;
        wr_sh_d = wr_sh_q;
        dout_d = dout_q;
        result_read_done = 1'b0;
        gpo_write = 1'b0;
        gpo_wdata = {wr_sh_q[6:0], spi.din};
        cmd_full = {cmd_sh_q[6:0], spi.din};
        if (spi.cs_n) begin
            phase_d = PH_CMD;
            cnt_d = 6'h00;
            dout_d = 1'b0;
        end else begin
            case (phase_q)
                PH_CMD: begin
                    if (sclk_rise) begin
                        cmd_sh_d = cmd_full;
                        cnt_d = cnt_q + 6'h01;
                        if (cnt_q == `CMD_BITS - 6'h01) begin
                            cnt_d = 6'h00;
                            rs_d = cmd_full[`CMD_RS_MSB:`CMD_RS_LSB];
                            if (cmd_full[`CMD_WEN_N_BIT]) begin
                                phase_d = PH_CMD;
                            end else if (cmd_full[`CMD_READ_BIT]) begin
                                phase_d = PH_READ;
                                len_d = `REG8_BITS;
                                rd_sh_d = 32'h0000_0000;
                                if (rs_d == `RS_RESULT) begin
                                    if (APPEND_STATUS_ENABLE_I) begin
                                        rd_sh_d = {conv_q.data, status_word};
                                        len_d = `RESULT_STATUS_BITS;
                                    end else begin
                                        rd_sh_d = {conv_q.data, 8'h00};
                                        len_d = `RESULT_BITS;
                                    end
                                end else if (rs_d == `RS_IDENT) begin
                                    rd_sh_d = {ID_VALUE, 24'h00_0000};
                                end else if (rs_d == `RS_GPO_CTL) begin
                                    rd_sh_d = {gpo_read, 24'h00_0000};
                                end else if (rs_d == `RS_STATUS) begin
                                    rd_sh_d = {status_word, 24'h00_0000};
                                end
                            end else begin
                                phase_d = PH_WRITE;
                            end
                        end
                    end
                end
                PH_READ: begin
                    // data changes on falling edge, msb first
                    if (sclk_fall) begin
                        dout_d = rd_sh_q[31];
                        rd_sh_d = {rd_sh_q[30:0], 1'b0};
                    end
                    if (sclk_rise) begin
                        cnt_d = cnt_q + 6'h01;
                        if (cnt_q == len_q - 6'h01) begin
                            phase_d = PH_CMD;
                            cnt_d = 6'h00;
                            result_read_done = (rs_q == `RS_RESULT);
                        end
                    end
                end
                PH_WRITE: begin
                    if (sclk_rise) begin
                        wr_sh_d = gpo_wdata;
                        cnt_d = cnt_q + 6'h01;
                        if (cnt_q == `REG8_BITS - 6'h01) begin
                            phase_d = PH_CMD;
                            cnt_d = 6'h00;
                            gpo_write = (rs_q == `RS_GPO_CTL);
                        end
                    end
                end
                default: begin
                    phase_d = PH_CMD;
                end
            endcase
        end
    end

    // serial engine registers
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            phase_q <= PH_CMD;
            cnt_q <= 6'h00;
            len_q <= 6'h00;
            rs_q <= 3'b000;
            cmd_sh_q <= 8'h00;
            rd_sh_q <= 32'h0000_0000;
            wr_sh_q <= 8'h00;
            dout_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            cnt_q <= cnt_d;
            len_q <= len_d;
            rs_q <= rs_d;
            cmd_sh_q <= cmd_sh_d;
            rd_sh_q <= rd_sh_d;
            wr_sh_q <= wr_sh_d;
            dout_q <= dout_d;
        end
    end

    // ==========================================
    // result, ready flag and output control
    always_comb begin
        conv_d = conv_q;
        rdy_d = rdy_q;
        gpo_d = gpo_q;
        if (CONV_DONE_I) begin
            conv_d.data = CONV_RESULT_I;
            conv_d.chan = pos_code_q;
            rdy_d = 1'b0;
        end else if (result_read_done) begin
            rdy_d = 1'b1;
        end
        if (gpo_write) begin
            gpo_d = gpo_wdata;
        end
    end

    // new conversion wins over a finishing read
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            conv_q <= {`RESULT_RESET, 4'h0};
            rdy_q <= `STATUS_READY_RESET;
            gpo_q <= `GPO_RESET;
        end else begin
            conv_q <= conv_d;
            rdy_q <= rdy_d;
            gpo_q <= gpo_d;
        end
    end

    // ==========================================
    // outputs
    assign SPI_DOUT_O = dout_q;
    assign SPI_DOUT_OE_O = ~spi.cs_n;
    assign READY_O = rdy_q;
    assign POS_INPUT_CODE_O = pos_code_q;
    assign NEG_INPUT_CODE_O = neg_code_q;
    assign NEG_IS_COMMON_O = neg_common_q;
    assign GP_PIN_OE_O = {upper_en, upper_en, lower_en, lower_en};
    assign GP_PIN_O[3] = gpo_q[3] & upper_en;
    assign GP_PIN_O[2] = gpo_q[2] & upper_en;
    assign GP_PIN_O[1:0] = gpo_q[1:0] & {2{lower_en}};
    assign UPPER_ANALOG_O = route_q.upper_analog;
    assign LOWER_REF2_O = route_q.lower_ref2;
    assign LOWER_ANALOG_O = route_q.lower_analog;

endmodule : adc_regs

// >>> inc/adc_regs_defs.svh
// register offsets, field positions, reset values and counts
// assumes inclusion by bare name from design files
`ifndef ADC_REGS_DEFS_SVH
`define ADC_REGS_DEFS_SVH

// ==========================================
// register select codes
`define RS_STATUS 3'b000
`define RS_RESULT 3'b011
`define RS_IDENT 3'b100
`define RS_GPO_CTL 3'b101

// ==========================================
// command byte fields
`define CMD_WEN_N_BIT 7
`define CMD_READ_BIT 6
`define CMD_RS_MSB 5
`define CMD_RS_LSB 3

// ==========================================
// output control fields
`define GPO_UPPER_EN_BIT 5
`define GPO_LOWER_EN_BIT 4
`define GPO_RESET 8'h00

// ==========================================
// result and status
`define RESULT_RESET 24'h00_0000
`define STATUS_READY_BIT 7
`define STATUS_READY_RESET 1'b1

// ==========================================
// serial frame lengths in bits
`define CMD_BITS 6'h08
`define REG8_BITS 6'h08
`define RESULT_BITS 6'h18
`define RESULT_STATUS_BITS 6'h20

`endif

// >>> inc/adc_regs_pkg.sv
// types shared by the register bank files
// assumes nothing beyond a SystemVerilog compiler
package adc_regs_pkg;

    // ==========================================
    // serial transfer phase
    typedef enum logic [1:0] {
        PH_CMD,
        PH_READ,
        PH_WRITE
    } spi_phase_e;

    // ==========================================
    // synchronised serial pins
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
    } spi_pins_s;

    // ==========================================
    // latched conversion
    typedef struct packed {
        logic [23:0] data;
        logic [3:0] chan;
    } conv_s;

    // ==========================================
    // analog routing of the shared pins
    typedef struct packed {
        logic upper_analog;
        logic lower_ref2;
        logic lower_analog;
    } route_s;

endpackage : adc_regs_pkg

// >>> rtl/sync_two_stage.sv
// two flip-flop synchroniser for a bundle of asynchronous levels
// assumes each bit is an independent level
`timescale 1ns/1ps
module sync_two_stage #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0 // idle level of each pin
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] stab_q;
    logic [WIDTH-1:0] stab_d;

    // ==========================================
    // next values
    always_comb begin
        meta_d = async_i;
        stab_d = meta_q;
    end

    // first stage read only by the second
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_q <= RESET_VAL;
            stab_q <= RESET_VAL;
        end else begin
            meta_q <= meta_d;
            stab_q <= stab_d;
        end
    end

    assign sync_o = stab_q;

endmodule : sync_two_stage

// >>> test/adc_regs_properties.sv
// concurrent checks on the ports of the register bank top module
// assumes one core clock and a synchronous active-low reset
`timescale 1ns/1ps
module adc_regs_properties (
    input wire logic CORE_CLK_I,
    input wire logic RESETN_I,
    input wire logic SPI_CS_N_I,
    input wire logic SPI_DOUT_O,
    input wire logic SPI_DOUT_OE_O,
    input wire logic READY_O,
    input wire logic [7:0] CHAN_SEL_I,
    input wire logic PSEUDO_I,
    input wire logic REFERENCE_SELECT_I,
    input wire logic CONV_DONE_I,
    input wire logic [3:0] POS_INPUT_CODE_O,
    input wire logic [3:0] NEG_INPUT_CODE_O,
    input wire logic NEG_IS_COMMON_O,
    input wire logic [3:0] GP_PIN_O,
    input wire logic [3:0] GP_PIN_OE_O,
    input wire logic UPPER_ANALOG_O,
    input wire logic LOWER_REF2_O,
    input wire logic LOWER_ANALOG_O
);
    // ====
    // clocking and reset for all checks
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);

    // ====
    // output pins
    chk_upper_pair: assert property (GP_PIN_OE_O[3] == GP_PIN_OE_O[2])
        else $error("upper pin enables differ");
    chk_lower_pair: assert property (GP_PIN_OE_O[1] == GP_PIN_OE_O[0])
        else $error("lower pin enables differ");
    chk_drive_gated: assert property ((GP_PIN_O & ~GP_PIN_OE_O) == 4'h0)
        else $error("level shown on undriven pin");

    // ====
    // analog routing one cycle behind the enables
    chk_upper_analog: assert property ($past(RESETN_I) |-> UPPER_ANALOG_O == !$past(GP_PIN_OE_O[3]))
        else $error("upper analog route wrong");
    chk_lower_ref: assert property ($past(RESETN_I) |->
        LOWER_REF2_O == (!$past(GP_PIN_OE_O[0]) && $past(REFERENCE_SELECT_I)))
        else $error("second reference route wrong");
    chk_lower_analog: assert property ($past(RESETN_I) |->
        LOWER_ANALOG_O == (!$past(GP_PIN_OE_O[0]) && !$past(REFERENCE_SELECT_I)))
        else $error("lower analog route wrong");

    // ====
    // channel decode
    chk_pos_code: assert property ($past(RESETN_I) |-> POS_INPUT_CODE_O == $past(CHAN_SEL_I[7:4]))
        else $error("positive code wrong");
    chk_neg_common: assert property ($past(RESETN_I) |-> NEG_IS_COMMON_O == $past(PSEUDO_I))
        else $error("common negative flag wrong");
    chk_neg_code: assert property ($past(RESETN_I) && $past(PSEUDO_I) |-> NEG_INPUT_CODE_O == 4'h0)
        else $error("negative code not zero");

    // ====
    // ready and serial idle
    chk_ready_clear: assert property (CONV_DONE_I |=> !READY_O)
        else $error("ready stays set after conversion");
    chk_idle_dout: assert property (SPI_CS_N_I [*4] |-> !SPI_DOUT_OE_O && !SPI_DOUT_O)
        else $error("serial out active while deselected");
endmodule : adc_regs_properties

// >>> test/spi_host_model.sv
// serial host: 4-wire master, mode 3, msb first
// assumes its strobes change on the falling core clock edge
`timescale 1ns/1ps
module spi_host_model (
    input wire logic clk_i,
    input wire logic dout_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o,
    output logic rd_done_o,
    output logic [31:0] rd_data_o
);
    localparam int HALF = 6; // core cycles per serial half period

    // ====
    // idle levels at time zero
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        din_o = 1'b0;
        rd_done_o = 1'b0;
        rd_data_o = 32'h0000_0000;
    end

    // shift n bits out of w, msb first, sample at rise
    task automatic shift(input logic [31:0] w, input int n);
        rd_data_o = 32'h0000_0000;
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge clk_i);
            sclk_o = 1'b0;
            din_o = w[i];
            repeat (HALF) @(negedge clk_i);
            sclk_o = 1'b1;
            rd_data_o = {rd_data_o[30:0], dout_i};
            repeat (HALF - 1) @(negedge clk_i);
        end
    endtask : shift

    // one framed transfer: command byte then n data bits
    task automatic xfer(input logic [7:0] cmd, input logic [31:0] w, input int n);
        @(negedge clk_i);
        cs_n_o = 1'b0;
        shift({24'h00_0000, cmd}, 8);
        shift(w, n);
        repeat (HALF) @(negedge clk_i);
        cs_n_o = 1'b1;
        din_o = ~din_o; // released line shows inverse
        rd_done_o = cmd[6];
        @(negedge clk_i);
        rd_done_o = 1'b0;
        repeat (HALF) @(negedge clk_i);
    endtask : xfer
endmodule : spi_host_model

// >>> test/adc_result_and_gpo_registers_test.sv
// self-checking bench for the result and output control registers
// assumes the serial host model and the checker beside it
`include "adc_regs_defs.svh"
`timescale 1ns/1ps
module adc_result_and_gpo_registers_test;
    import adc_regs_pkg::*;
    localparam logic [7:0] ID_VAL = 8'h5C; // arbitrary identification value
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk, cs_n, din, dout, dout_oe, ready, rd_done;
    logic [31:0] rd_data;
    logic [7:0] chan_sel = 8'h00;
    logic pseudo = 1'b0;
    logic append = 1'b0;
    logic ref_sel = 1'b0;
    logic conv_done = 1'b0;
    logic [23:0] conv_res = 24'h00_0000;
    logic [23:0] res;
    logic [3:0] pos_code, neg_code, gp_out, gp_oe, gp_pin, en;
    logic [3:0] gp_ext = 4'h0;
    logic [3:0] gp_clash = 4'h0;
    logic neg_com, up_an, lo_ref, lo_an;
    logic [7:0] v;
    logic [31:0] expq[$];
    int failures = 0;
    int tests_run = 0;

    // ====
    // clock and pin resolution
    always #12.5 clk = ~clk;
    // clash bits model an outside driver overpowering a driven pin
    assign gp_pin = (gp_oe & (gp_out ^ gp_clash)) | (~gp_oe & gp_ext);

    adc_regs #(.ID_VALUE(ID_VAL)) i_adc_regs (
        .CORE_CLK_I(clk), .RESETN_I(rst_n), .SPI_SCLK_I(sclk), .SPI_CS_N_I(cs_n),
        .SPI_DIN_I(din), .SPI_DOUT_O(dout), .SPI_DOUT_OE_O(dout_oe), .READY_O(ready),
        .CHAN_SEL_I(chan_sel), .PSEUDO_I(pseudo), .APPEND_STATUS_ENABLE_I(append),
        .REFERENCE_SELECT_I(ref_sel), .CONV_DONE_I(conv_done), .CONV_RESULT_I(conv_res),
        .POS_INPUT_CODE_O(pos_code), .NEG_INPUT_CODE_O(neg_code), .NEG_IS_COMMON_O(neg_com),
        .GP_PIN_I(gp_pin), .GP_PIN_O(gp_out), .GP_PIN_OE_O(gp_oe), .UPPER_ANALOG_O(up_an),
        .LOWER_REF2_O(lo_ref), .LOWER_ANALOG_O(lo_an));
    spi_host_model i_spi_host_model (.clk_i(clk), .dout_i(dout), .sclk_o(sclk), .cs_n_o(cs_n),
        .din_o(din), .rd_done_o(rd_done), .rd_data_o(rd_data));

    // ====
    // compare, report and bus tasks
    task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : compare
    task automatic tally_and_finish;
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    task automatic rd(input logic [2:0] rs, input logic [31:0] exp, input int n);
        expq.push_back(exp);
        i_spi_host_model.xfer({2'b01, rs, 3'b000}, 32'h0000_0000, n);
    endtask : rd
    task automatic wr(input logic [2:0] rs, input logic [7:0] w);
        i_spi_host_model.xfer({2'b00, rs, 3'b000}, {24'h00_0000, w}, 8);
    endtask : wr

    // read watcher takes the oldest note
    always @(posedge rd_done) begin
        compare("read", expq.size() > 0 ? expq.pop_front() : 32'hxxxx_xxxx, rd_data);
    end

    // watchdog
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        tally_and_finish();
    end

    // ====
    // main sequence
    initial begin
        void'($urandom(32'h0000_3be3));
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        compare("ready", 32'h1, {31'h0, ready});
        rd(`RS_GPO_CTL, 32'h0000_0000, 8);
        rd(`RS_RESULT, 32'h0000_0000, 24);
        rd(`RS_IDENT, {24'h00_0000, ID_VAL}, 8);
        for (int k = 0; k < 8; k++) begin
            v = {2'b00, 2'(k), 4'($urandom)};
            ref_sel = 1'(k >> 2);
            gp_ext = 4'($urandom);
            gp_clash = 4'($urandom);
            wr(`RS_GPO_CTL, v);
            en = {{2{v[5]}}, {2{v[4]}}};
            compare("enable", {28'h0, en}, {28'h0, gp_oe});
            compare("level", {28'h0, v[3:0] & en}, {28'h0, gp_out});
            compare("route", {29'h0, !v[5], !v[4] && ref_sel, !v[4] && !ref_sel},
                {29'h0, up_an, lo_ref, lo_an});
            rd(`RS_GPO_CTL, {24'h00_0000, v[7:4], (v[3:0] & ~en) | ((v[3:0] ^ gp_clash) & en)}, 8);
        end
        for (int k = 0; k < 4; k++) begin
            chan_sel = 8'($urandom);
            pseudo = 1'(k);
            append = 1'(k >> 1);
            res = 24'($urandom);
            repeat (2) @(negedge clk);
            compare("pos", {28'h0, chan_sel[7:4]}, {28'h0, pos_code});
            compare("neg", {27'h0, pseudo, pseudo ? 4'h0 : chan_sel[3:0]}, {27'h0, neg_com, neg_code});
            conv_res = res;
            conv_done = 1'b1;
            @(negedge clk);
            conv_done = 1'b0;
            conv_res = ~res;
            @(negedge clk);
            compare("ready", 32'h0, {31'h0, ready});
            rd(`RS_RESULT, append ? {res, 4'h0, chan_sel[7:4]} : {8'h00, res}, append ? 32 : 24);
            compare("ready", 32'h1, {31'h0, ready});
            wr(`RS_RESULT, 8'hFF);
            wr(`RS_IDENT, 8'h00);
        end
        append = 1'b0;
        rd(`RS_RESULT, {8'h00, res}, 24);
        rd(`RS_IDENT, {24'h00_0000, ID_VAL}, 8);
        rd(`RS_STATUS, {24'h00_0000, 4'h8, chan_sel[7:4]}, 8);
        repeat (4) @(negedge clk);
        compare("pending", 32'h0, expq.size());
        tally_and_finish();
    end
endmodule : adc_result_and_gpo_registers_test

bind adc_regs adc_regs_properties i_adc_regs_properties (.CORE_CLK_I, .RESETN_I, .SPI_CS_N_I,
    .SPI_DOUT_O, .SPI_DOUT_OE_O, .READY_O, .CHAN_SEL_I, .PSEUDO_I, .REFERENCE_SELECT_I,
    .CONV_DONE_I, .POS_INPUT_CODE_O, .NEG_INPUT_CODE_O, .NEG_IS_COMMON_O, .GP_PIN_O,
    .GP_PIN_OE_O, .UPPER_ANALOG_O, .LOWER_REF2_O, .LOWER_ANALOG_O);
